// [shared/ut_pkg.sv]
`default_nettype none
package ut_pkg;
    // Register byte addresses
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_DIV = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;
    localparam logic [7:0] ADR_DATA = 8'h0C;
    // Control register fields
    localparam int CTRL_W = 14;
    localparam int C_CHAN = 0;
    localparam int C_TXEN = 1;
    localparam int C_RXEN = 2;
    localparam int C_WL9 = 3;
    localparam int C_PEN = 4;
    localparam int C_PTY = 5;
    localparam int C_STOP2 = 7;
    localparam int C_TX9 = 8;
    localparam int C_BRK = 9;
    localparam int C_TEIE = 10;
    localparam int C_FRAC = 11;
    localparam logic [13:0] CTRL_RST = 14'h0000;
    localparam logic [15:0] DIV_RST = 16'h0010;
    // Status register fields
    localparam int S_TXE = 0;
    localparam int S_TIDLE = 1;
    localparam int S_RIDLE = 2;
    localparam int S_RXA = 3;
    localparam int S_OVR = 4;
    localparam int S_FRM = 5;
    localparam int S_PAR = 6;
    localparam int S_NOISE = 7;
    localparam int S_RX9 = 8;
    localparam int S_CNT = 9;
    // Parity type codes
    localparam logic [1:0] PAR_EVEN = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h1;
    localparam logic [1:0] PAR_MARK = 2'h2;
    localparam logic [1:0] PAR_SPACE = 2'h3;
    // Frame figures
    localparam logic [3:0] LAST_BIT8 = 4'h7;
    localparam logic [3:0] LAST_BIT9 = 4'h8;
    localparam logic [3:0] BRK_ZEROS = 4'hD;
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_STOP1, TX_STOP2, TX_BRK
    } ut_tx_state_t;
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_STOP1, RX_STOP2, RX_WAIT
    } ut_rx_state_t;
endpackage
`default_nettype wire

// [rtl/ut_baud.sv]
`timescale 1ns/10ps
`default_nettype none
module ut_baud #(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    input wire logic [DIV_W-1:0] div_i,
    input wire logic [2:0] frac_i,
    // Strobes
    output logic tick_o,
    output logic smp_o
);
    logic [DIV_W-1:0] cnt_ff;
    logic [2:0] acc_ff;
    logic [3:0] sum;
    logic [DIV_W-1:0] lim;
    logic [DIV_W-1:0] half;

    initial begin
        if (DIV_W < 4) $error("ut_baud: DIV_W too small");
    end

    // Carry out of the fraction sum stretches this bit
    assign sum = {1'b0, acc_ff} + {1'b0, frac_i};
    assign lim = div_i - {{(DIV_W-1){1'b0}}, 1'b1}
        + {{(DIV_W-1){1'b0}}, sum[3]};
    assign half = div_i >> 1;
    assign tick_o = run_i && (cnt_ff == lim);
    // Three sample points around mid-bit
    assign smp_o = run_i && (cnt_ff == half
        || cnt_ff == half + {{(DIV_W-1){1'b0}}, 1'b1}
        || cnt_ff == half + {{(DIV_W-2){1'b0}}, 2'h2});

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i || tick_o) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            acc_ff <= 3'h0;
        end else if (tick_o) begin
            acc_ff <= sum[2:0];
        end
    end
endmodule // ut_baud
`default_nettype wire

// [rtl/ut_rx_front.sv]
`timescale 1ns/10ps
`default_nettype none
module ut_rx_front (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Line and sample strobe
    input wire logic pin_i,
    input wire logic smp_i,
    // Recovered level
    output logic line_o,
    output logic maj_o,
    output logic noise_o
);
    logic meta_ff;
    logic sync_ff;
    logic [2:0] smp_ff;

    // Two-stage synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            smp_ff <= 3'h7;
        end else if (smp_i) begin
            smp_ff <= {smp_ff[1:0], sync_ff};
        end
    end

    assign line_o = sync_ff;
    // Majority of three samples
    assign maj_o = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & smp_ff[2])
        | (smp_ff[1] & smp_ff[2]);
    assign noise_o = !(&smp_ff) && (|smp_ff);
endmodule // ut_rx_front
`default_nettype wire

// [rtl/ut_core.sv]
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - all enables set: pins serial, idle high
// - channel off frees pins, empties buffers
// - channel off clears flags, sets idle flags
// - channel off stops transfers, clears enable and break bits, keeps rest of configuration
// - word length eight or nine bits
// - parity odd, even, mark, space in last
// - receiver one/two stops, transmitter always two
// - nine-bit mode: top bit from control, or parity when enabled
// - shifter loads only after stop bits
// - start needs enable, data and baud
// - transmit enable off stops and resets transmitter
// - frames leave least significant bit first
// - data writes ignored while empty flag low
// - status read then data write clears flags
// - empty flag set when holding free, interrupt
// - idle write loads shifter, sets empty flag
// - idle flag set after stops or break
// - held break request makes next frame break
// - breaks repeat while held, no interrupt
// - nine-bit mode: received top bit stored
// - majority of three mid-bit samples
// - received word stored when register free
// - fraction accumulator carry stretches bit
module ut_core #(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial pins
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic tx_pin_select_o,
    output logic rx_pin_select_o,
    // Transmit empty interrupt
    output logic tx_empty_irq_o
);
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic [13:0] ctrl_ff;
    logic [13:0] nxt_ctrl;
    logic [DIV_W-1:0] div_ff;
    logic [31:0] wmask;
    logic req, wr, rd, arm_ff;
    logic chan, tx_en, rx_en, wl9;
    logic [3:0] last_bit;
    logic [7:0] hold_ff;
    logic hold_full_ff, tx_empty_ff, tx_idle_ff, dat_wr, dat_ok;
    ut_pkg::ut_tx_state_t tx_st;
    logic [8:0] tsr_ff;
    logic [3:0] tx_cnt_ff;
    logic [DIV_W:0] brk_cnt_ff;
    logic brk_go, tx_tick, tx_smp;
    logic [8:0] tx_word;
    logic sout_ff;
    ut_pkg::ut_rx_state_t rx_st;
    logic rx_tick, rx_smp, line, maj, noise;
    logic [8:0] rsr_ff;
    logic [3:0] rx_cnt_ff;
    logic frm_acc_ff, noise_acc_ff, rx_done;
    logic [8:0] rx_word;
    logic [7:0] rx_data_ff;
    logic rx9_ff, rxa_ff, ovr_ff, frm_ff, par_ff, nf_ff;
    logic txsel_ff, rxsel_ff, irq_ff;
    logic [31:0] stat;

    initial begin
        if (DIV_W < 4 || DIV_W > 16) $error("ut_core: DIV_W out of range");
    end

    function automatic logic par_f(input logic [1:0] t, input logic x);
        case (t)
            ut_pkg::PAR_EVEN: par_f = x;
            ut_pkg::PAR_ODD: par_f = !x;
            ut_pkg::PAR_MARK: par_f = 1'b1;
            default: par_f = 1'b0;
        endcase
    endfunction

    // Bus decode
    assign req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign chan = ctrl_ff[ut_pkg::C_CHAN];
    assign tx_en = chan && ctrl_ff[ut_pkg::C_TXEN];
    assign rx_en = chan && ctrl_ff[ut_pkg::C_RXEN];
    assign wl9 = ctrl_ff[ut_pkg::C_WL9];
    assign last_bit = wl9 ? ut_pkg::LAST_BIT9 : ut_pkg::LAST_BIT8;
    assign stat = {20'h00000, (rxa_ff ? 3'h1 : 3'h0), rx9_ff, nf_ff,
        par_ff, frm_ff, ovr_ff, rxa_ff, (rx_st == ut_pkg::RX_IDLE),
        tx_idle_ff, tx_empty_ff};

    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr && wb_adr_i == ut_pkg::ADR_CTRL) begin
            nxt_ctrl = (ctrl_ff & ~wmask[13:0]) | (wb_dat_i[13:0] & wmask[13:0]);
        end
        if (!nxt_ctrl[ut_pkg::C_CHAN]) begin
            nxt_ctrl[ut_pkg::C_TXEN] = 1'b0;
            nxt_ctrl[ut_pkg::C_RXEN] = 1'b0;
            nxt_ctrl[ut_pkg::C_BRK] = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= ut_pkg::CTRL_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ff <= ut_pkg::DIV_RST[DIV_W-1:0];
        end else if (wr && wb_adr_i == ut_pkg::ADR_DIV) begin
            div_ff <= (div_ff & ~wmask[DIV_W-1:0])
                | (wb_dat_i[DIV_W-1:0] & wmask[DIV_W-1:0]);
        end
    end

    // Read mux and acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h00000000;
        end else begin
            ack_ff <= req;
            if (rd) begin
                if (wb_adr_i == ut_pkg::ADR_CTRL) begin
                    rdat_ff <= {18'h00000, ctrl_ff};
                end else if (wb_adr_i == ut_pkg::ADR_DIV) begin
                    rdat_ff <= {{(32-DIV_W){1'b0}}, div_ff};
                end else if (wb_adr_i == ut_pkg::ADR_STAT) begin
                    rdat_ff <= stat;
                end else if (wb_adr_i == ut_pkg::ADR_DATA) begin
                    rdat_ff <= {23'h000000, rx9_ff, rx_data_ff};
                end else begin
                    rdat_ff <= 32'h00000000;
                end
            end
        end
    end

    // Status read arms the flag-clearing data access
    always_ff @(posedge clk_i) begin
        if (rst_i || !chan) begin
            arm_ff <= 1'b0;
        end else if (rd && wb_adr_i == ut_pkg::ADR_STAT) begin
            arm_ff <= 1'b1;
        end else if (req && wb_adr_i == ut_pkg::ADR_DATA) begin
            arm_ff <= 1'b0;
        end
    end

    assign dat_wr = wr && wb_adr_i == ut_pkg::ADR_DATA && wb_sel_i[0];
    assign dat_ok = dat_wr && chan && tx_empty_ff && !hold_full_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i || !chan) begin
            hold_ff <= 8'h00;
            hold_full_ff <= 1'b0;
        end else if (dat_ok) begin
            hold_ff <= wb_dat_i[7:0];
            hold_full_ff <= 1'b1;
        end else if (tx_st == ut_pkg::TX_IDLE && tx_en && !brk_go) begin
            hold_full_ff <= 1'b0;
        end
    end

    // Transmit flags: hardware set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i || !chan) begin
            tx_empty_ff <= 1'b1;
            tx_idle_ff <= 1'b1;
        end else begin
            if (dat_ok && arm_ff) begin
                tx_empty_ff <= 1'b0;
                tx_idle_ff <= 1'b0;
            end
            if (tx_st == ut_pkg::TX_IDLE && tx_en && hold_full_ff && !brk_go) begin
                tx_empty_ff <= 1'b1;
            end
            if (tx_st == ut_pkg::TX_STOP2 && tx_tick) begin
                tx_idle_ff <= 1'b1;
            end
        end
    end

    // Held break request arms a break frame
    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl_ff[ut_pkg::C_BRK] || tx_st != ut_pkg::TX_IDLE) begin
            brk_cnt_ff <= '0;
        end else if (!brk_go) begin
            brk_cnt_ff <= brk_cnt_ff + {{DIV_W{1'b0}}, 1'b1};
        end
    end
    assign brk_go = brk_cnt_ff > {1'b0, div_ff} + {{DIV_W{1'b0}}, 1'b1};

    // Frame word, parity in last position
    always_comb begin
        tx_word = {ctrl_ff[ut_pkg::C_TX9], hold_ff};
        if (!wl9) begin
            tx_word[8] = 1'b0;
            if (ctrl_ff[ut_pkg::C_PEN]) begin
                tx_word[7] = par_f(ctrl_ff[6:5], ^hold_ff[6:0]);
            end
        end else if (ctrl_ff[ut_pkg::C_PEN]) begin
            tx_word[8] = par_f(ctrl_ff[6:5], ^hold_ff);
        end
    end

    ut_baud #(
        .DIV_W(DIV_W)
    ) u_tx_baud (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(tx_st != ut_pkg::TX_IDLE),
        .div_i(div_ff),
        .frac_i(ctrl_ff[13:11]),
        .tick_o(tx_tick),
        .smp_o(tx_smp)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_en) begin
            tx_st <= ut_pkg::TX_IDLE;
            tsr_ff <= 9'h000;
            tx_cnt_ff <= 4'h0;
        end else begin
            case (tx_st)
                ut_pkg::TX_IDLE: begin
                    tx_cnt_ff <= 4'h0;
                    if (brk_go) begin
                        tx_st <= ut_pkg::TX_BRK;
                    end else if (hold_full_ff) begin
                        tsr_ff <= tx_word;
                        tx_st <= ut_pkg::TX_START;
                    end
                end
                ut_pkg::TX_START: begin
                    if (tx_tick) begin
                        tx_st <= ut_pkg::TX_DATA;
                    end
                end
                ut_pkg::TX_DATA: begin
                    if (tx_tick) begin
                        tsr_ff <= tsr_ff >> 1;
                        tx_cnt_ff <= tx_cnt_ff + 4'h1;
                        if (tx_cnt_ff == last_bit) begin
                            tx_st <= ut_pkg::TX_STOP1;
                        end
                    end
                end
                ut_pkg::TX_STOP1: begin
                    if (tx_tick) begin
                        tx_st <= ut_pkg::TX_STOP2;
                    end
                end
                ut_pkg::TX_STOP2: begin
                    if (tx_tick) begin
                        tx_st <= ut_pkg::TX_IDLE;
                    end
                end
                default: begin
                    if (tx_tick) begin
                        tx_cnt_ff <= tx_cnt_ff + 4'h1;
                        if (tx_cnt_ff == ut_pkg::BRK_ZEROS) begin
                            if (ctrl_ff[ut_pkg::C_BRK]) begin
                                tx_cnt_ff <= 4'h1;
                            end else begin
                                tx_st <= ut_pkg::TX_STOP1;
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sout_ff <= 1'b1;
        end else if (tx_st == ut_pkg::TX_START || tx_st == ut_pkg::TX_BRK) begin
            sout_ff <= 1'b0;
        end else if (tx_st == ut_pkg::TX_DATA) begin
            sout_ff <= tsr_ff[0];
        end else begin
            sout_ff <= 1'b1;
        end
    end

    // Receiver
    ut_rx_front u_front (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(serial_in_pin_i),
        .smp_i(rx_smp),
        .line_o(line),
        .maj_o(maj),
        .noise_o(noise)
    );

    ut_baud #(
        .DIV_W(DIV_W)
    ) u_rx_baud (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(rx_st != ut_pkg::RX_IDLE && rx_st != ut_pkg::RX_WAIT),
        .div_i(div_ff),
        .frac_i(ctrl_ff[13:11]),
        .tick_o(rx_tick),
        .smp_o(rx_smp)
    );

    assign rx_done = rx_tick && (rx_st == ut_pkg::RX_STOP2
        || (rx_st == ut_pkg::RX_STOP1 && !ctrl_ff[ut_pkg::C_STOP2]));
    assign rx_word = wl9 ? rsr_ff : {1'b0, rsr_ff[8:1]};

    always_ff @(posedge clk_i) begin
        if (rst_i || !rx_en) begin
            rx_st <= ut_pkg::RX_IDLE;
            rsr_ff <= 9'h000;
            rx_cnt_ff <= 4'h0;
            frm_acc_ff <= 1'b0;
            noise_acc_ff <= 1'b0;
        end else begin
            case (rx_st)
                ut_pkg::RX_IDLE: begin
                    rx_cnt_ff <= 4'h0;
                    frm_acc_ff <= 1'b0;
                    noise_acc_ff <= 1'b0;
                    if (!line) begin
                        rx_st <= ut_pkg::RX_START;
                    end
                end
                ut_pkg::RX_START: begin
                    if (rx_tick) begin
                        noise_acc_ff <= noise;
                        rx_st <= maj ? ut_pkg::RX_IDLE : ut_pkg::RX_DATA;
                    end
                end
                ut_pkg::RX_DATA: begin
                    if (rx_tick) begin
                        rsr_ff <= {maj, rsr_ff[8:1]};
                        noise_acc_ff <= noise_acc_ff | noise;
                        rx_cnt_ff <= rx_cnt_ff + 4'h1;
                        if (rx_cnt_ff == last_bit) begin
                            rx_st <= ut_pkg::RX_STOP1;
                        end
                    end
                end
                ut_pkg::RX_STOP1: begin
                    if (rx_tick) begin
                        frm_acc_ff <= !maj;
                        noise_acc_ff <= noise_acc_ff | noise;
                        rx_st <= ctrl_ff[ut_pkg::C_STOP2] ? ut_pkg::RX_STOP2
                            : (maj ? ut_pkg::RX_IDLE : ut_pkg::RX_WAIT);
                    end
                end
                ut_pkg::RX_STOP2: begin
                    if (rx_tick) begin
                        rx_st <= (maj && !frm_acc_ff) ? ut_pkg::RX_IDLE
                            : ut_pkg::RX_WAIT;
                    end
                end
                default: begin
                    if (line) begin
                        rx_st <= ut_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    // Receive flags: delivery wins over the read-clear
    always_ff @(posedge clk_i) begin
        if (rst_i || !chan) begin
            rx_data_ff <= 8'h00;
            rx9_ff <= 1'b0;
            rxa_ff <= 1'b0;
            ovr_ff <= 1'b0;
            frm_ff <= 1'b0;
            par_ff <= 1'b0;
            nf_ff <= 1'b0;
        end else begin
            if (arm_ff && rd && wb_adr_i == ut_pkg::ADR_DATA) begin
                rxa_ff <= 1'b0;
                ovr_ff <= 1'b0;
                frm_ff <= 1'b0;
                par_ff <= 1'b0;
                nf_ff <= 1'b0;
            end
            if (rx_done && rxa_ff) begin
                ovr_ff <= 1'b1;
            end else if (rx_done) begin
                rx_data_ff <= rx_word[7:0];
                rx9_ff <= wl9 & rx_word[8];
                rxa_ff <= 1'b1;
                frm_ff <= frm_acc_ff | !maj;
                nf_ff <= noise_acc_ff | noise;
                par_ff <= ctrl_ff[ut_pkg::C_PEN] && (wl9
                    ? rx_word[8] != par_f(ctrl_ff[6:5], ^rx_word[7:0])
                    : rx_word[7] != par_f(ctrl_ff[6:5], ^rx_word[6:0]));
            end
        end
    end

    // Pin ownership and interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txsel_ff <= 1'b0;
            rxsel_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            txsel_ff <= tx_en;
            rxsel_ff <= rx_en;
            irq_ff <= chan && tx_empty_ff && ctrl_ff[ut_pkg::C_TEIE];
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    assign serial_out_pin_o = sout_ff;
    assign tx_pin_select_o = txsel_ff;
    assign rx_pin_select_o = rxsel_ff;
    assign tx_empty_irq_o = irq_ff;

    property p_idle_high;
        @(posedge clk_i) disable iff (rst_i)
        tx_st == ut_pkg::TX_IDLE |=> serial_out_pin_o;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line low idle");

    property p_disable;
        @(posedge clk_i) disable iff (rst_i)
        !chan |-> !ctrl_ff[ut_pkg::C_TXEN] ##1 (tx_empty_ff && tx_idle_ff
            && !rxa_ff && rx_st == ut_pkg::RX_IDLE);
    endproperty
    a_disable: assert property (p_disable) else $error("disable state");

    property p_txen_off;
        @(posedge clk_i) disable iff (rst_i)
        !tx_en |=> tx_st == ut_pkg::TX_IDLE;
    endproperty
    a_txen_off: assert property (p_txen_off) else $error("tx not reset");

    property p_start_cause;
        @(posedge clk_i) disable iff (rst_i)
        $rose(tx_st == ut_pkg::TX_START) |-> $past(tx_en && hold_full_ff);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("bad start");

    property p_wr_ignored;
        @(posedge clk_i) disable iff (rst_i)
        (dat_wr && !tx_empty_ff) |=> $stable(hold_ff);
    endproperty
    a_wr_ignored: assert property (p_wr_ignored) else $error("overwrite");

    property p_clear_seq;
        @(posedge clk_i) disable iff (rst_i)
        $fell(tx_idle_ff) |-> $past(arm_ff && dat_ok);
    endproperty
    a_clear_seq: assert property (p_clear_seq) else $error("idle cleared");

    property p_stop_high;
        @(posedge clk_i) disable iff (rst_i)
        tx_st == ut_pkg::TX_STOP2 && tx_tick |=> tx_idle_ff ##1 serial_out_pin_o;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stop end");

    property p_rx_store;
        @(posedge clk_i) disable iff (rst_i)
        rx_done && !rxa_ff && chan |=> rxa_ff && !ovr_ff[*1];
    endproperty
    a_rx_store: assert property (p_rx_store) else $error("rx not stored");
endmodule // ut_core
`default_nettype wire

// [testbench/ut_remote.sv]
`timescale 1ns/10ps
`default_nettype none
module ut_remote #(
    parameter int BT = 16
) (
    // Clock and lines
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    int nb = 8;
    logic [11:0] f;
    logic [11:0] got_q[$];
    initial line_o = 1'b1;
    // Capture whole frame, start to second stop
    always begin
        @(negedge line_i);
        f = 12'h000;
        repeat (BT / 2) @(posedge clk_i);
        for (int i = 0; i < nb + 3; i++) begin
            if (i > 0) repeat (BT) @(posedge clk_i);
            f[i] = line_i;
        end
        got_q.push_back(f);
    end
    // Send one frame, two stops
    task automatic send(input logic [8:0] d);
        logic [11:0] s;
        s = (12'h003 << (nb + 1)) | {d, 1'b0};
        for (int i = 0; i < nb + 3; i++) begin
            @(posedge clk_i);
            line_o <= s[i];
            repeat (BT - 1) @(posedge clk_i);
        end
    endtask
endmodule // ut_remote
`default_nettype wire

// [testbench/tb_ut_core.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_ut_core;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, q, st;
    logic wb_ack_o, so, si, txs, rxs, irq;
    logic [8:0] d, e;
    logic [11:0] exp_q[$];
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    always #20 clk_i = ~clk_i;
    ut_core ut_core_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_in_pin_i(si),
        .serial_out_pin_o(so), .tx_pin_select_o(txs),
        .rx_pin_select_o(rxs), .tx_empty_irq_o(irq));
    ut_remote #(.BT(16)) ut_remote_inst (.clk_i(clk_i), .line_i(so),
        .line_o(si));
    task automatic report_and_stop();
        $display("checks %0d fails %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] v);
        int t;
        t = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= v;
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (t >= 20) n_fail++;
    endtask
    task automatic tx(input logic [8:0] v);
        wb(1'b0, ut_pkg::ADR_STAT, 32'h0);
        st = q;
        wb(1'b1, ut_pkg::ADR_DATA, {23'h0, v});
    endtask
    function automatic logic [11:0] frm(logic [8:0] v, int n);
        return (12'h003 << (n + 1)) | {v, 1'b0};
    endfunction
    task automatic drain();
        repeat (3000)
            if (ut_remote_inst.got_q.size() < exp_q.size()) @(posedge clk_i);
        chk(ut_remote_inst.got_q.size(), exp_q.size());
        while (exp_q.size() > 0 && ut_remote_inst.got_q.size() > 0)
            chk(ut_remote_inst.got_q.pop_front(), exp_q.pop_front());
    endtask
    initial begin
        void'($urandom(32'hA1474493));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, ut_pkg::ADR_STAT, 32'h0);
        chk(q, 32'h7);
        wb(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, ut_pkg::ADR_CTRL, 32'h407);
        repeat (2) @(posedge clk_i);
        chk({so, txs, rxs, irq}, 4'hF);
        for (int i = 0; i < 3; i++) begin
            d = {1'b0, 8'($urandom)};
            tx(d);
            chk(st[0], i < 2);
            if (i < 2) exp_q.push_back(frm(d, 8));
        end
        drain();
        for (int p = 0; p < 4; p++) begin
            wb(1'b1, ut_pkg::ADR_CTRL, 32'h17 | (p << 5));
            d = {1'b0, 8'($urandom)};
            e = d;
            e[7] = (p == 0) ? ^d[6:0] : (p == 1) ? ~^d[6:0] : (p == 2);
            exp_q.push_back(frm(e, 8));
            tx(d);
            drain();
        end
        wb(1'b1, ut_pkg::ADR_CTRL, 32'h10F);
        ut_remote_inst.nb = 9;
        d = {1'b0, 8'($urandom)};
        exp_q.push_back(frm({1'b1, d[7:0]}, 9));
        tx(d);
        drain();
        wb(1'b1, ut_pkg::ADR_CTRL, 32'h30F);
        repeat (40) @(posedge clk_i);
        wb(1'b1, ut_pkg::ADR_CTRL, 32'h10F);
        exp_q.push_back(12'h000);
        drain();
        d = 9'($urandom);
        ut_remote_inst.send(d);
        wb(1'b0, ut_pkg::ADR_STAT, 32'h0);
        chk(q[8:0], {d[8], 8'h0F});
        wb(1'b0, ut_pkg::ADR_DATA, 32'h0);
        chk(q, {23'h0, d});
        wb(1'b1, ut_pkg::ADR_CTRL, 32'h11F);
        d = 9'($urandom);
        ut_remote_inst.send(d);
        wb(1'b0, ut_pkg::ADR_STAT, 32'h0);
        chk(q[6], d[8] ^ (^d[7:0]));
        wb(1'b1, ut_pkg::ADR_CTRL, 32'h109);
        wb(1'b1, ut_pkg::ADR_CTRL, 32'h108);
        wb(1'b0, ut_pkg::ADR_CTRL, 32'h0);
        chk(q, 32'h108);
        wb(1'b0, ut_pkg::ADR_DIV, 32'h0);
        chk(q, 32'h10);
        wb(1'b0, ut_pkg::ADR_STAT, 32'h0);
        chk(q & ~32'h100, 32'h7);
        chk({txs, rxs}, 2'b00);
        report_and_stop();
    end
endmodule // tb_ut_core
`default_nettype wire
